// ===== disr_pkg.sv
// Notes on behaviour
// - There are two request outputs, each with its own 32-bit enable register and 32-bit flag register, where an enable of one lets the source through and zero blocks it.
// - An event sets its flag to one whatever its enable bit holds.
// - A request output goes low while any of its flags is one and the matching enable bit is also one.
// - Writing a one to a flag bit clears it unless its event lands in that cycle, so writing back the value read clears every flag seen set with no new event.
// - A request output that is low stays low until every set flag that is enabled has been cleared by a write or had its enable bit written to zero.
// - After reset every enable bit is zero, so all maskable sources are off.
// - The reset-complete source cannot be masked, and bit 15 of the second enable register has no effect on it.
// - When any reset completes, bit 15 of the second flag register is set and the second request output goes low, until a one is written to that bit.
// - Bits 0 to 2 of the second set are the total, fundamental and apparent no-load events, whose phases are given in a separate no-load detail register.
// - Bits 16 to 18 of the second set pair with a phase event detail register, and bits 23 and 24 pair with the current and voltage peak detail registers.
// - In the first set, bits 6 to 8, 10 to 12 and 9, 13 and 18 are sign reversal events that pair with a phase sign detail register.
package disr_pkg;
   // =========================================================
   // register map
   localparam logic [1:0] DISR_ADDR_ENABLE_A = 2'h0;
   localparam logic [1:0] DISR_ADDR_ENABLE_B = 2'h1;
   localparam logic [1:0] DISR_ADDR_FLAG_A = 2'h2;
   localparam logic [1:0] DISR_ADDR_FLAG_B = 2'h3;
   localparam logic [31:0] DISR_ENABLE_RST = 32'h0000_0000;
   localparam logic [31:0] DISR_FLAG_RST = 32'h0000_0000;
   // =========================================================
   // field positions
   localparam int DISR_RESET_COMPLETE_BIT = 15;
   localparam int DISR_TOTAL_NOLOAD_BIT = 0;
   localparam int DISR_FUND_NOLOAD_BIT = 1;
   localparam int DISR_APPARENT_NOLOAD_BIT = 2;
   localparam int DISR_VOLTAGE_DIP_BIT = 16;
   localparam int DISR_OVERCURRENT_BIT = 17;
   localparam int DISR_OVERVOLTAGE_BIT = 18;
   localparam int DISR_CURRENT_PEAK_BIT = 23;
   localparam int DISR_VOLTAGE_PEAK_BIT = 24;
   // bits whose cause is held in a detail register
   localparam logic [31:0] DISR_DETAIL_MASK_A = 32'h0004_3FC0;
   localparam logic [31:0] DISR_DETAIL_MASK_B = 32'h0187_0007;
   localparam logic [31:0] DISR_UNMASKABLE_B = 32'h0000_8000;
   // =========================================================
   // register access carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] addr;
      logic [31:0] wdata;
   } disr_req_t;
endpackage

// ===== disr_top.sv
module disr_top
   import disr_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire disr_req_t i_req,
   input wire logic [31:0] i_event_a,
   input wire logic [31:0] i_event_b,
   output logic [31:0] o_rdata,
   output logic o_request_out_a_n,
   output logic o_request_out_b_n
);
   // =========================================================
   // reset release
   logic rst_meta_q;
   logic rst_sync_q;
   // async assert, two-flop release so all state leaves reset together
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // =========================================================
   // registers
   logic [31:0] enable_a_q, enable_a_d;
   logic [31:0] enable_b_q, enable_b_d;
   logic [31:0] flag_a_q, flag_a_d;
   logic [31:0] flag_b_q, flag_b_d;
   logic [31:0] rdata_q, rdata_d;
   logic req_a_n_q, req_a_n_d;
   logic req_b_n_q, req_b_n_d;
   logic done_q, done_d;
   logic [31:0] reset_event_b;

   // flag update: set wins over clear, zeros in a write keep the flag
   function automatic logic [31:0] flag_next(input logic [31:0] cur,
                                             input logic [31:0] ev,
                                             input logic clr,
                                             input logic [31:0] wd);
      logic [31:0] kept;
      kept = clr ? (cur & ~wd) : cur;
      return kept | ev;
   endfunction

   // write decode shared by every register group
   function automatic logic is_write(input disr_req_t r,
                                     input logic [1:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // =========================================================
   // reset-complete event
   // one pulse on the first cycle after release; the internal reset
   // covers power-up and pin resets alike, so every reset ends with it
   always_comb begin
      reset_event_b = '0;
      reset_event_b[DISR_RESET_COMPLETE_BIT] = ~done_q;
      done_d = 1'b1;
   end

   // done stays high until the next reset re-arms the pulse
   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         done_q <= 1'b0;
      end else begin
         done_q <= done_d;
      end
   end

   // =========================================================
   // enable registers
   // plain storage; bit 15 of set b is kept so software reads back
   // what it wrote, even though the request logic ignores it
   always_comb begin
      enable_a_d = enable_a_q;
      enable_b_d = enable_b_q;
      if (is_write(i_req, DISR_ADDR_ENABLE_A)) begin
         enable_a_d = i_req.wdata;
      end
      if (is_write(i_req, DISR_ADDR_ENABLE_B)) begin
         enable_b_d = i_req.wdata;
      end
   end

   // enables come up cleared so no maskable source fires early
   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         enable_a_q <= DISR_ENABLE_RST;
         enable_b_q <= DISR_ENABLE_RST;
      end else begin
         enable_a_q <= enable_a_d;
         enable_b_q <= enable_b_d;
      end
   end

   // =========================================================
   // flag registers
   // events land regardless of enables
   // detail registers live outside; only the flag bits are kept here
   always_comb begin
      flag_a_d = flag_next(flag_a_q, i_event_a,
                           is_write(i_req, DISR_ADDR_FLAG_A),
                           i_req.wdata);
      flag_b_d = flag_next(flag_b_q, i_event_b | reset_event_b,
                           is_write(i_req, DISR_ADDR_FLAG_B),
                           i_req.wdata);
   end

   // flags start clear; the reset-complete pulse sets bit 15 next
   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         flag_a_q <= DISR_FLAG_RST;
         flag_b_q <= DISR_FLAG_RST;
      end else begin
         flag_a_q <= flag_a_d;
         flag_b_q <= flag_b_d;
      end
   end

   // =========================================================
   // request outputs
   // built from next values so the pin moves on the same edge as the
   // flag; registering it keeps the pin free of glitches while several
   // flags and enables change together
   always_comb begin
      req_a_n_d = ~|(flag_a_d & enable_a_d);
      req_b_n_d = ~|(flag_b_d & (enable_b_d | DISR_UNMASKABLE_B));
   end

   // requests idle high (released) while in reset
   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         req_a_n_q <= 1'b1;
         req_b_n_q <= 1'b1;
      end else begin
         req_a_n_q <= req_a_n_d;
         req_b_n_q <= req_b_n_d;
      end
   end

   // =========================================================
   // read data
   // holds the last value read; a read and a write in one cycle return
   // the value before the write
   always_comb begin
      rdata_d = rdata_q;
      if (i_req.rd) begin
         case (i_req.addr)
            DISR_ADDR_ENABLE_A: rdata_d = enable_a_q;
            DISR_ADDR_ENABLE_B: rdata_d = enable_b_q;
            DISR_ADDR_FLAG_A: rdata_d = flag_a_q;
            DISR_ADDR_FLAG_B: rdata_d = flag_b_q;
            default: rdata_d = '0;
         endcase
      end
   end

   // read data clears in reset
   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // outputs straight from the flops
   assign o_rdata = rdata_q;
   assign o_request_out_a_n = req_a_n_q;
   assign o_request_out_b_n = req_b_n_q;

   // =========================================================
   // checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!rst_sync_q);

   AST_PIN_A: assert property (req_a_n_q == ~|(flag_a_q & enable_a_q))
      else $error("request a does not match flags and enables");
   AST_PIN_B: assert property (req_b_n_q ==
      ~|(flag_b_q & (enable_b_q | DISR_UNMASKABLE_B)))
      else $error("request b does not match flags and enables");
   AST_SET: assert property (i_event_a[6] |=> flag_a_q[6])
      else $error("event a6 did not set its flag");
   // every bit written as one with no event in that cycle is cleared
   AST_CLR: assert property (i_req.wr && i_req.addr == DISR_ADDR_FLAG_A
      |=> (flag_a_q & $past(i_req.wdata) & ~$past(i_event_a))
      == 32'h0000_0000)
      else $error("write one did not clear a flag");
   // every set bit written as zero survives the write
   AST_KEEP: assert property (i_req.wr && i_req.addr == DISR_ADDR_FLAG_A
      |=> (flag_a_q | ~$past(flag_a_q) | $past(i_req.wdata))
      == 32'hFFFF_FFFF)
      else $error("write zero cleared a flag");
   // an event in the cycle of a clearing write still sets its flag
   AST_SETWIN: assert property (i_req.wr && i_req.addr == DISR_ADDR_FLAG_A
      |=> (flag_a_q | ~$past(i_event_a)) == 32'hFFFF_FFFF)
      else $error("event lost to simultaneous clear");
   // clearing all enabled flags with no new enabled event frees pin a
   AST_REL_A: assert property (i_req.wr && i_req.addr == DISR_ADDR_FLAG_A
      && (flag_a_q & enable_a_q & ~i_req.wdata) == 32'h0000_0000
      && (i_event_a & enable_a_q) == 32'h0000_0000 |=> req_a_n_q)
      else $error("request a stuck after full clear");
   // a read of flag set b returns the flags of the cycle it was taken
   AST_RD_B: assert property (i_req.rd && i_req.addr == DISR_ADDR_FLAG_B
      |=> o_rdata == $past(flag_b_q))
      else $error("read data differs from flag set b");
   // enables are still clear when the reset-complete pulse lands
   AST_EN_RST: assert property ($rose(done_q)
      |-> (enable_a_q | enable_b_q) == 32'h0000_0000)
      else $error("enables not cleared by reset");
   AST_UNMASK: assert property (flag_b_q[DISR_RESET_COMPLETE_BIT]
      |-> !req_b_n_q)
      else $error("reset-complete flag masked");
   AST_HOLD: assert property (!req_a_n_q && !(i_req.wr &&
      (i_req.addr == DISR_ADDR_FLAG_A || i_req.addr == DISR_ADDR_ENABLE_A))
      |=> !req_a_n_q)
      else $error("request a released without a write");
   AST_DONE: assert property ($rose(done_q) |-> !req_b_n_q
      && flag_b_q[DISR_RESET_COMPLETE_BIT])
      else $error("reset-complete not raised after reset");
   COV_IRQ_A: cover property ($fell(req_a_n_q));
   COV_REL_A: cover property ($rose(req_a_n_q));
   COV_SETWIN: cover property (i_req.wr && i_req.addr == DISR_ADDR_FLAG_A
      && |(i_req.wdata & i_event_a));
   COV_REL_B: cover property ($rose(req_b_n_q));
   COV_DONE: cover property ($rose(done_q));
endmodule

// ===== disr_host.sv
module disr_host
   import disr_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic [31:0] i_rdata,
   output disr_req_t o_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========================================================
   // host register access
   initial o_req = '0;
   // one-cycle strobe, data inverted once released so stale values show
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_core_clk);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // read data lands one cycle after the strobe is taken
   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'hA5A5_A5A5};
      @(posedge i_core_clk);
      o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'h5A5A_5A5A};
      @(posedge i_core_clk);
      #1 d = i_rdata;
   endtask
   // service: read flags, detail reads would sit here, then write back
   task automatic service(input logic [1:0] a, output logic [31:0] d);
      rd(a, d);
      wr(a, d);
   endtask
endmodule

// ===== disr_top_tb.sv
module disr_top_tb;
   import disr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [31:0] ev_a = '0, ev_b = '0, rdata, v;
   logic irq_a_n, irq_b_n;
   disr_req_t req;
   int error_cnt = 0, checked = 0;
   // =========================================================
   // clock, design and host
   always #25 i_core_clk = ~i_core_clk;
   disr_top i_disr_top(.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_req(req), .i_event_a(ev_a), .i_event_b(ev_b), .o_rdata(rdata),
      .o_request_out_a_n(irq_a_n), .o_request_out_b_n(irq_b_n));
   disr_host i_disr_host(.i_core_clk(i_core_clk), .i_rdata(rdata),
      .o_req(req));
   // =========================================================
   // helpers
   task automatic chk(input logic [31:0] seen, exp, input string m);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // pin moves on the same edge as the flags; wait two edges before sampling
   task automatic settle;
      repeat (2) @(posedge i_core_clk);
      #1;
   endtask
   task automatic pulse(input logic [31:0] a, b);
      @(posedge i_core_clk);
      ev_a <= a;
      ev_b <= b;
      @(posedge i_core_clk);
      ev_a <= '0;
      ev_b <= '0;
   endtask
   task automatic rdchk(input logic [1:0] a, input logic [31:0] e);
      i_disr_host.rd(a, v);
      chk(v, e, "register read");
   endtask
   // =========================================================
   // scenarios
   task automatic t_reset;
      rdchk(DISR_ADDR_ENABLE_A, DISR_ENABLE_RST);
      rdchk(DISR_ADDR_ENABLE_B, DISR_ENABLE_RST);
      rdchk(DISR_ADDR_FLAG_B, 32'h0000_8000);
      chk(32'(irq_b_n), 32'h0, "reset done pin");
      i_disr_host.wr(DISR_ADDR_FLAG_B, 32'h0000_8000);
      settle;
      chk(32'(irq_b_n), 32'h1, "reset done clear");
   endtask
   // masked flags record silently; pin drops only once enabled
   task automatic t_mask;
      pulse(32'h0000_0040, 32'h0000_0001);
      settle;
      chk(32'({irq_a_n, irq_b_n}), 32'h3, "masked pins");
      rdchk(DISR_ADDR_FLAG_A, 32'h0000_0040);
      i_disr_host.wr(DISR_ADDR_ENABLE_A, 32'h0000_0440);
      settle;
      chk(32'(irq_a_n), 32'h0, "enabled pin a");
      pulse(32'h0000_0400, 32'h0);
      i_disr_host.wr(DISR_ADDR_FLAG_A, 32'h0000_0040);
      settle;
      chk(32'(irq_a_n), 32'h0, "other flag holds pin");
      rdchk(DISR_ADDR_FLAG_A, 32'h0000_0400);
      i_disr_host.service(DISR_ADDR_FLAG_A, v);
      settle;
      chk(32'(irq_a_n), 32'h1, "pin a released");
      i_disr_host.wr(DISR_ADDR_ENABLE_B, 32'h0000_8001);
      settle;
      chk(32'(irq_b_n), 32'h0, "enabled pin b");
      i_disr_host.service(DISR_ADDR_FLAG_B, v);
      chk(v, 32'h0000_0001, "no-load flag");
      settle;
      chk(32'(irq_b_n), 32'h1, "pin b released");
   endtask
   // event landing on the clearing write must win
   task automatic t_race;
      pulse(32'h0004_0000, 32'h0);
      fork
         i_disr_host.wr(DISR_ADDR_FLAG_A, 32'h0004_0000);
         pulse(32'h0004_0000, 32'h0);
      join
      rdchk(DISR_ADDR_FLAG_A, 32'h0004_0000);
      i_disr_host.service(DISR_ADDR_FLAG_A, v);
      rdchk(DISR_ADDR_FLAG_A, 32'h0);
   endtask
   // =========================================================
   // run control
   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      t_reset;
      t_mask;
      t_race;
      report_and_stop;
   end
   // the scenarios need about 80 cycles; this is far beyond
   initial begin
      #100_000;
      error_cnt++;
      report_and_stop;
   end
endmodule
